/* hw/sdcc_pkg.sv */
// constants shared by the sensor drive current control block
package sdcc_pkg;
    // -------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CODE_W = 5;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int SAMPLE_W = 12;
    // -------------------------------------------------------------
    // register offsets and field positions
    // -------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_DRIVE [NUM_CH] = '{
        8'h1E, 8'h1F, 8'h20, 8'h21
    };
    localparam int PROG_LSB = 11;
    localparam int CAL_LSB = 6;
    localparam int CFG_FIXED_BIT = 12;
    localparam int CFG_AMP_DIS_BIT = 10;
    // -------------------------------------------------------------
    // codes and reset values
    // -------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
    localparam logic [CODE_W-1:0] CODE_MIN = 5'h00;
    localparam logic [CODE_W-1:0] CODE_MAX = 5'h1F;
    localparam logic [CODE_W-1:0] CODE_STEP = 5'h01;
    localparam logic [CODE_W-1:0] CODE_195UA = 5'h11;
    localparam logic [REG_W-1:0] RDATA_RESET = 16'h0000;
endpackage

/* hw/sdcc_channel.sv */
// one channel: programmed drive code, calibrated code and search
`timescale 1ns/1ps
module sdcc_channel
    import sdcc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [CODE_W-1:0] wr_code,
    input wire logic conv_end,
    input wire logic loop_on,
    input wire logic start_search,
    input wire logic amp_low,
    input wire logic amp_high,
    output logic [CODE_W-1:0] prog_code,
    output logic [CODE_W-1:0] cal_code,
    output logic searching
);
    logic [CODE_W-1:0] prog_q;
    logic [CODE_W-1:0] cal_q;
    logic search_q;
    logic step;

    // -------------------------------------------------------------
    // programmed code
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_q <= CODE_RESET;
        end else if (clk_en && wr_en) begin
            prog_q <= wr_code;
        end
    end

    // -------------------------------------------------------------
    // calibrated code: search and amplitude loop
    // -------------------------------------------------------------
    assign step = conv_end && (search_q || loop_on);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_q <= CODE_RESET;
            search_q <= 1'b0;
        end else if (clk_en) begin
            if (start_search) begin
                search_q <= 1'b1;
                cal_q <= prog_q;
            end else if (step) begin
                if (amp_low && cal_q != CODE_MAX) begin
                    cal_q <= cal_q + CODE_STEP;
                end else if (amp_high && cal_q != CODE_MIN) begin
                    cal_q <= cal_q - CODE_STEP;
                end else begin
                    search_q <= 1'b0;
                end
            end
        end
    end

    assign prog_code = prog_q;
    assign cal_code = cal_q;
    assign searching = search_q;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_step_up_low: assert property (
        clk_en && step && !start_search && amp_low && cal_q != CODE_MAX
        |=> cal_q == $past(cal_q) + CODE_STEP)
        else $error("code did not rise on low amplitude");
    a_step_down_high: assert property (
        clk_en && step && !start_search && !amp_low && amp_high
        && cal_q != CODE_MIN |=> cal_q == $past(cal_q) - CODE_STEP)
        else $error("code did not fall on high amplitude");
    a_cal_only_moves: assert property (
        !(clk_en && (step || start_search)) |=> $stable(cal_q))
        else $error("calibrated code moved without cause");
    a_search_ends_win: assert property (
        clk_en && search_q && conv_end && !start_search
        && !amp_low && !amp_high |=> !search_q && $stable(cal_q))
        else $error("search did not stop inside window");
endmodule

/* hw/sdcc_top.sv */
// sensor drive current control: drive codes, pin grounding, search
//
// Notes on behaviour
// - drive code is monotonic current index
// - inactive channel pins grounded; all when idle
// - only active channel driven during its conversion
// - auto selection searches window on active entry
// - amplitude loop steps codes between conversions
// - loop changes update calibrated code field
// - stopped oscillation yields all zero samples
// - loop disable is configuration bit ten
`timescale 1ns/1ps
module sdcc_top
    import sdcc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [REG_W-1:0] reg_wdata,
    output logic [REG_W-1:0] reg_rdata,
    input wire logic [REG_W-1:0] cfg_word,
    input wire logic sleep_mode,
    input wire logic shutdown,
    input wire logic [1:0] active_ch,
    input wire logic conv_active,
    input wire logic conv_done,
    input wire logic amp_low_pin,
    input wire logic amp_high_pin,
    input wire logic osc_stop_pin,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] sample_raw,
    output logic sample_out_valid,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic [NUM_CH*CODE_W-1:0] drive_code,
    output logic [NUM_CH-1:0] drive_en,
    output logic [NUM_CH-1:0] ground_en,
    output logic [NUM_CH-1:0] searching
);
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic amp_low_s;
    logic amp_high_s;
    logic osc_stop_s;
    logic fixed_sel;
    logic loop_on;
    logic use_cal;
    logic idle;
    logic idle_q;
    logic start_search;
    logic [CODE_W-1:0] prog [NUM_CH];
    logic [CODE_W-1:0] cal [NUM_CH];
    logic [NUM_CH-1:0] drive_d;
    logic [NUM_CH*CODE_W-1:0] code_d;
    logic [REG_W-1:0] rd_word;
    logic [REG_W-1:0] rdata_q;
    logic [NUM_CH-1:0] drive_en_q;
    logic [NUM_CH-1:0] ground_en_q;
    logic [NUM_CH*CODE_W-1:0] drive_code_q;
    logic sample_valid_q;
    logic [SAMPLE_W-1:0] sample_q;

    // -------------------------------------------------------------
    // analog comparator synchronisers
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else if (clk_en) begin
            sync1_q <= {osc_stop_pin, amp_high_pin, amp_low_pin};
            sync2_q <= sync1_q;
        end
    end

    assign amp_low_s = sync2_q[0];
    assign amp_high_s = sync2_q[1];
    assign osc_stop_s = sync2_q[2];

    // -------------------------------------------------------------
    // mode decode
    // -------------------------------------------------------------
    assign fixed_sel = cfg_word[CFG_FIXED_BIT];
    assign loop_on = !cfg_word[CFG_AMP_DIS_BIT];
    assign use_cal = !fixed_sel || loop_on;
    assign idle = sleep_mode || shutdown;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_q <= 1'b1;
        end else if (clk_en) begin
            idle_q <= idle;
        end
    end

    // entry to active mode with auto selection starts a search
    assign start_search = idle_q && !idle && !fixed_sel;

    // -------------------------------------------------------------
    // channels
    // -------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        sdcc_channel u_ch (
            .clk(clk),
            .arst_n(arst_n),
            .clk_en(clk_en),
            .wr_en(reg_wr && reg_addr == ADDR_DRIVE[i]),
            .wr_code(reg_wdata[PROG_LSB +: CODE_W]),
            .conv_end(conv_done && !idle && active_ch == 2'(i)),
            .loop_on(loop_on),
            .start_search(start_search),
            .amp_low(amp_low_s),
            .amp_high(amp_high_s),
            .prog_code(prog[i]),
            .cal_code(cal[i]),
            .searching(searching[i])
        );
    end

    // -------------------------------------------------------------
    // register read
    // -------------------------------------------------------------
    always_comb begin
        rd_word = RDATA_RESET;
        for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == ADDR_DRIVE[i]) begin
                rd_word[PROG_LSB +: CODE_W] = prog[i];
                rd_word[CAL_LSB +: CODE_W] = cal[i];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= RDATA_RESET;
        end else if (clk_en && reg_rd) begin
            rdata_q <= rd_word;
        end
    end

    // -------------------------------------------------------------
    // sensor drive and grounding
    // -------------------------------------------------------------
    always_comb begin
        drive_d = '0;
        if (!idle && conv_active) begin
            drive_d = NUM_CH'(1) << active_ch;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            // code indexes the current ladder directly
            code_d[i*CODE_W +: CODE_W] = use_cal ? cal[i] : prog[i];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_en_q <= '0;
            ground_en_q <= '1;
            drive_code_q <= '0;
        end else if (clk_en) begin
            drive_en_q <= drive_d;
            ground_en_q <= ~drive_d;
            drive_code_q <= code_d;
        end
    end

    // -------------------------------------------------------------
    // sample output
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_valid_q <= 1'b0;
            sample_q <= '0;
        end else if (clk_en) begin
            sample_valid_q <= sample_valid;
            if (sample_valid) begin
                sample_q <= osc_stop_s ? '0 : sample_raw;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign drive_en = drive_en_q;
    assign ground_en = ground_en_q;
    assign drive_code = drive_code_q;
    assign sample_out_valid = sample_valid_q;
    assign sample_out = sample_q;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_idle_all_ground: assert property (
        clk_en && idle |=> ground_en_q == '1 && drive_en_q == '0)
        else $error("idle device left a channel ungrounded");
    a_drive_excl_ground: assert property (
        (drive_en_q & ground_en_q) == '0 && $onehot0(drive_en_q))
        else $error("channel driven and grounded or two driven");
    a_drive_follows_act: assert property (
        clk_en && conv_active && !idle
        |=> drive_en_q == NUM_CH'(1) << $past(active_ch))
        else $error("active channel not driven");
    a_done_then_ground: assert property (
        clk_en && !conv_active |=> drive_en_q == '0)
        else $error("sensor driven outside conversion");
    a_search_on_entry: assert property (
        clk_en && idle_q && !idle && !fixed_sel |=> searching == '1)
        else $error("search not started on active entry");
    a_fixed_uses_prog: assert property (
        clk_en && fixed_sel && !loop_on
        |=> drive_code_q[CODE_W-1:0] == $past(prog[0]))
        else $error("fixed drive not taken from programmed code");
    a_stop_zero_out: assert property (
        clk_en && sample_valid && osc_stop_s
        |=> sample_valid_q && sample_q == '0)
        else $error("stopped sensor gave nonzero sample");
    a_rsvd_read_zero: assert property (
        clk_en && reg_rd |=> rdata_q[CAL_LSB-1:0] == '0)
        else $error("reserved drive bits read nonzero");

    c_search_done: cover property (searching[0] ##1 !searching[0]);
    c_code_195ua: cover property (cal[0] == CODE_195UA && loop_on);
    c_zero_sample: cover property (sample_valid && osc_stop_s && clk_en);
    c_two_channels: cover property (drive_en_q[0] ##[1:20] drive_en_q[1]);
endmodule

/* dv/sdcc_coil.sv */
// lc sensor coil model: amplitude comparators of the driven channel
`timescale 1ns/1ps
module sdcc_coil
    import sdcc_pkg::*;
(
    input wire logic [NUM_CH*CODE_W-1:0] drive_code,
    input wire logic [NUM_CH-1:0] drive_en,
    input wire logic [NUM_CH*CODE_W-1:0] tgt,
    output logic amp_low,
    output logic amp_high,
    output logic osc_stop
);
    int c;
    int t;
    logic on;
    // an undriven or grounded coil has no oscillation at all
    always_comb begin
        c = 0;
        t = 0;
        on = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (drive_en[i]) begin
                on = 1'b1;
                c = int'(drive_code[i*CODE_W +: CODE_W]);
                t = int'(tgt[i*CODE_W +: CODE_W]);
            end
        end
        amp_low = !on || (c < t);
        amp_high = on && (c > t);
        osc_stop = !on || (c + 8 < t);
    end
endmodule

/* dv/tb.sv */
// testbench for the sensor drive current control block
`timescale 1ns/1ps
module tb;
    import sdcc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_W-1:0] reg_wdata = '0;
    logic [REG_W-1:0] reg_rdata;
    logic [REG_W-1:0] cfg_word = 16'h1400;
    logic sleep_mode = 1'b1;
    logic shutdown = 1'b0;
    logic [1:0] active_ch = 2'h0;
    logic conv_active = 1'b0;
    logic conv_done = 1'b0;
    logic amp_low, amp_high, osc_stop, sample_out_valid;
    logic sample_valid = 1'b0;
    logic [SAMPLE_W-1:0] sample_raw = '0;
    logic [SAMPLE_W-1:0] sample_out;
    logic [NUM_CH*CODE_W-1:0] drive_code;
    logic [NUM_CH*CODE_W-1:0] tgt = '0;
    logic [NUM_CH-1:0] drive_en, ground_en, searching;
    logic [CODE_W-1:0] prog [NUM_CH];
    logic [CODE_W-1:0] t1;
    logic [REG_W-1:0] exp_q [$];
    logic rd_d = 1'b0;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // -----------------------------------------------------------
    // clock, design and coil
    // -----------------------------------------------------------
    always #20 clk = ~clk;
    sdcc_top dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cfg_word(cfg_word), .sleep_mode(sleep_mode),
        .shutdown(shutdown), .active_ch(active_ch),
        .conv_active(conv_active), .conv_done(conv_done),
        .amp_low_pin(amp_low), .amp_high_pin(amp_high),
        .osc_stop_pin(osc_stop), .sample_valid(sample_valid),
        .sample_raw(sample_raw), .sample_out_valid(sample_out_valid),
        .sample_out(sample_out), .drive_code(drive_code),
        .drive_en(drive_en), .ground_en(ground_en),
        .searching(searching));
    sdcc_coil coil (.drive_code(drive_code), .drive_en(drive_en),
        .tgt(tgt), .amp_low(amp_low), .amp_high(amp_high),
        .osc_stop(osc_stop));
    // -----------------------------------------------------------
    // checking, watcher and closing
    // -----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d || sample_out_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h00000001, 32'h00000000);
            end else if (rd_d) begin
                chk(reg_rdata, exp_q.pop_front());
            end else begin
                chk(sample_out, exp_q.pop_front());
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            close_out();
        end
    end
    // -----------------------------------------------------------
    // register and conversion tasks
    // -----------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic conv(input int ch, input logic [CODE_W-1:0] e);
        logic [SAMPLE_W-1:0] raw;
        logic [NUM_CH-1:0] oh;
        raw = SAMPLE_W'($urandom);
        oh = NUM_CH'(1 << ch);
        @(posedge clk);
        active_ch <= 2'(ch);
        conv_active <= 1'b1;
        repeat (6) @(posedge clk);
        sample_valid <= 1'b1;
        sample_raw <= raw;
        exp_q.push_back((e + 8 < tgt[ch*CODE_W +: CODE_W]) ? '0 : 16'(raw));
        @(negedge clk);
        chk(drive_en, oh);
        chk(ground_en, NUM_CH'(~oh));
        chk(drive_code[ch*CODE_W +: CODE_W], e);
        @(posedge clk);
        sample_valid <= 1'b0;
        conv_active <= 1'b0;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        @(negedge clk);
        chk(ground_en, 4'hF);
    endtask
    task automatic settle(input int ch, input logic [CODE_W-1:0] e);
        logic [CODE_W-1:0] t;
        t = tgt[ch*CODE_W +: CODE_W];
        for (int k = 0; k < 40 && e != t; k++) begin
            conv(ch, e);
            if (e < t) begin
                e++;
            end else begin
                e--;
            end
        end
        conv(ch, e);
    endtask
    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        void'($urandom(32'h29d6287f));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk({drive_en, ground_en, searching}, 32'h000000F0);
        chk(drive_code, 32'h00000000);
        chk(reg_rdata, 32'h00000000);
        $display("test reset done");
        @(posedge clk);
        for (int i = 0; i < NUM_CH; i++) begin
            prog[i] = CODE_W'($urandom);
            tgt[i*CODE_W +: CODE_W] <= CODE_W'($urandom);
        end
        prog[2] = CODE_195UA;
        prog[3] = CODE_MIN;
        tgt[3*CODE_W +: CODE_W] <= CODE_MAX;
        for (int i = 0; i < NUM_CH; i++) begin
            wr(ADDR_DRIVE[i], {prog[i], 11'h7FF});
            rd(ADDR_DRIVE[i], {prog[i], 11'h000});
        end
        wr(8'h1D, 16'hFFFF);
        rd(8'h22, 16'h0000);
        // frozen clock enable: write ignored, read data held
        @(posedge clk);
        clk_en <= 1'b0;
        wr(ADDR_DRIVE[2], 16'h0000);
        rd(ADDR_DRIVE[2], 16'h0000);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(ADDR_DRIVE[2], {CODE_195UA, 11'h000});
        $display("test registers done");
        @(posedge clk);
        sleep_mode <= 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            conv(i, prog[i]);
        end
        chk(searching, 32'h00000000);
        $display("test fixed drive done");
        @(posedge clk);
        active_ch <= 2'h1;
        conv_active <= 1'b1;
        sleep_mode <= 1'b1;
        repeat (2) @(negedge clk);
        chk(ground_en, 4'hF);
        @(posedge clk);
        sleep_mode <= 1'b0;
        shutdown <= 1'b1;
        repeat (2) @(negedge clk);
        chk(ground_en, 4'hF);
        @(posedge clk);
        conv_active <= 1'b0;
        sleep_mode <= 1'b1;
        shutdown <= 1'b0;
        cfg_word <= 16'h0400;
        repeat (2) @(posedge clk);
        sleep_mode <= 1'b0;
        repeat (3) @(negedge clk);
        chk(searching, 4'hF);
        $display("test idle grounding done");
        settle(0, prog[0]);
        chk(searching, 4'hE);
        rd(ADDR_DRIVE[0], {prog[0], tgt[0 +: CODE_W], 6'h00});
        $display("test search done");
        @(posedge clk);
        cfg_word <= 16'h1000;
        t1 = CODE_W'($urandom);
        tgt[CODE_W +: CODE_W] <= t1;
        // let the new target land before the search reads it
        @(posedge clk);
        settle(1, prog[1]);
        rd(ADDR_DRIVE[1], {prog[1], t1, 6'h00});
        @(posedge clk);
        cfg_word <= 16'h1400;
        conv(1, prog[1]);
        wr(ADDR_DRIVE[1], {t1, 11'h000});
        conv(1, t1);
        $display("test amplitude loop done");
        repeat (4) @(posedge clk);
        chk(exp_q.size(), 32'h00000000);
        close_out();
    end
endmodule
